// ### rtl/fault_pin_share_response.sv
// Shared fault line drive, external pull detection, response and status for two pages.
`timescale 1ns/1ps

module fault_pin_share_response
   import fault_share_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire reg_access_s  reg_access,
   input  wire logic         clear_faults,
   input  wire page_faults_s faults_page0,
   input  wire page_faults_s faults_page1,
   input  wire logic         shared_fault_line_a_in,
   input  wire logic         shared_fault_line_b_in,
   output logic              shared_fault_line_a_out,
   output logic              shared_fault_line_a_oe,
   output logic              shared_fault_line_b_out,
   output logic              shared_fault_line_b_oe,
   output logic [1:0]        output_inhibit,
   output logic [7:0]        read_data,
   output logic              read_valid,
   output logic              byte_count_error,
   output logic              alert_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [7:0] response_reg  [PAGE_COUNT] = '{default: RESP_RESET};
   logic [7:0] response_next [PAGE_COUNT];
   logic [7:0] propagate_reg  [PAGE_COUNT];
   logic [7:0] propagate_next [PAGE_COUNT];
   logic [1:0] mask_reg, mask_next;
   logic [1:0] status_summary_reg, status_summary_next;
   logic [1:0] status_pin_reg, status_pin_next;
   logic [1:0] line_meta_reg, line_sync_reg;
   logic [1:0] drive_low_reg, drive_low_next;
   logic [1:0] drive_hist1_reg, drive_hist2_reg;
   logic [1:0] pulled_low;
   logic [1:0] inhibit_reg, inhibit_next;
   logic [7:0] read_data_next;
   logic       read_valid_next;
   logic       byte_err_reg, byte_err_next;
   logic       access_ok;

   // Gathers the faults that a page is allowed to share on its line.
   function automatic logic page_pull(input page_faults_s f, input logic [7:0] p);
      page_pull = (f.overtemp    & p[BIT_OVERTEMP])
                | (f.input_ov    & p[BIT_INPUT_OV])
                | (f.overcurrent & p[BIT_OVERCURRENT])
                | (f.out_uv      & p[BIT_OUT_UV])
                | (f.out_ov      & p[BIT_OUT_OV]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Line inputs arrive from other chips, so they pass two flops first.
   // Own drive is delayed alongside, to match what the synchroniser shows.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_meta_reg   <= 2'h3;
         line_sync_reg   <= 2'h3;
         drive_hist1_reg <= 2'h0;
         drive_hist2_reg <= 2'h0;
      end else begin
         line_meta_reg   <= {shared_fault_line_b_in, shared_fault_line_a_in};
         line_sync_reg   <= line_meta_reg;
         drive_hist1_reg <= drive_low_reg;
         drive_hist2_reg <= drive_hist1_reg;
      end
   end

   // A low line seen while this device is not pulling means someone outside pulls it.
   // Own drive is masked so our own fault does not trigger our own shutdown; the mask
   // stays two cycles past release, while the synchroniser still shows our own low.
   assign pulled_low = ~line_sync_reg & ~(drive_low_reg | drive_hist1_reg | drive_hist2_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Next state for registers, status, drive and response.
   always_comb begin
      for (int i = 0; i < PAGE_COUNT; i++) begin
         response_next[i]  = response_reg[i];
         propagate_next[i] = propagate_reg[i];
      end
      mask_next           = mask_reg;
      status_summary_next = status_summary_reg;
      status_pin_next     = status_pin_reg;
      read_data_next      = 8'h00;
      read_valid_next     = 1'b0;
      byte_err_next       = 1'b0;
      access_ok           = (reg_access.byte_count == 2'h1);

      // Own faults go only to the page's own line.
      drive_low_next[0] = page_pull(faults_page0, propagate_reg[0]);
      drive_low_next[1] = page_pull(faults_page1, propagate_reg[1]);

      // Inhibit only for the C0 code; 00 and anything else keep running.
      for (int i = 0; i < PAGE_COUNT; i++) begin
         inhibit_next[i] = pulled_low[i] & (response_reg[i] == RESP_INHIBIT);
      end

      if (reg_access.wr) begin
         if (!access_ok) begin
            byte_err_next = 1'b1;
         end else begin
            unique case (reg_access.code)
               CMD_FAULT_RESPONSE: response_next[reg_access.page] = reg_access.data;
               CMD_PROPAGATE_LOW:
                  propagate_next[reg_access.page] = reg_access.data & PROPAGATE_WR_MASK;
               CMD_ALERT_MASK: mask_next[reg_access.page] = reg_access.data[BIT_MFR_PIN_PULLED];
               default: byte_err_next = 1'b1;
            endcase
         end
      end

      if (reg_access.rd) begin
         read_valid_next = 1'b1;
         unique case (reg_access.code)
            CMD_FAULT_RESPONSE: read_data_next = response_reg[reg_access.page];
            CMD_PROPAGATE_LOW:  read_data_next = propagate_reg[reg_access.page];
            CMD_ALERT_MASK:
               read_data_next = {7'h00, mask_reg[reg_access.page]};
            CMD_STATUS_WORD_HI:
               read_data_next = 8'(status_summary_reg[reg_access.page]) << BIT_STATUS_MFR_SUMMARY;
            CMD_STATUS_MFR:
               read_data_next = {7'h00, status_pin_reg[reg_access.page]};
            default: read_data_next = 8'h00;
         endcase
      end

      // Clear first, then set, so a standing pull sets again at once.
      if (clear_faults) begin
         status_summary_next = 2'h0;
         status_pin_next     = 2'h0;
      end
      status_summary_next = status_summary_next | pulled_low;
      status_pin_next     = status_pin_next | pulled_low;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers. Response keeps its value through rst, as stored setup does.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < PAGE_COUNT; i++) begin
            propagate_reg[i] <= PROPAGATE_RESET;
         end
         mask_reg           <= ALERT_MASK_RESET[1:0];
         status_summary_reg <= 2'h0;
         status_pin_reg     <= 2'h0;
         drive_low_reg      <= 2'h0;
         inhibit_reg        <= 2'h0;
         read_data          <= 8'h00;
         read_valid         <= 1'b0;
         byte_err_reg       <= 1'b0;
      end else begin
         propagate_reg      <= propagate_next;
         mask_reg           <= mask_next;
         status_summary_reg <= status_summary_next;
         status_pin_reg     <= status_pin_next;
         drive_low_reg      <= drive_low_next;
         inhibit_reg        <= inhibit_next;
         read_data          <= read_data_next;
         read_valid         <= read_valid_next;
         byte_err_reg       <= byte_err_next;
      end
   end

   // Response values model non-volatile storage: power-up value, never reset.
   always_ff @(posedge clk_sys) begin
      response_reg <= response_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain drive: data always low, enable pulls.
   assign shared_fault_line_a_out = 1'b0;
   assign shared_fault_line_b_out = 1'b0;
   assign shared_fault_line_a_oe  = drive_low_reg[0];
   assign shared_fault_line_b_oe  = drive_low_reg[1];
   assign output_inhibit          = inhibit_reg;
   assign byte_count_error        = byte_err_reg;
   assign alert_n                 = ~|(status_pin_reg & ~mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   AST_OT_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
      faults_page0.overtemp && propagate_reg[0][BIT_OVERTEMP] |=> shared_fault_line_a_oe)
      else $error("Over-temperature did not pull line a.");
   AST_IOV_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
      faults_page1.input_ov && propagate_reg[1][BIT_INPUT_OV] |=> shared_fault_line_b_oe)
      else $error("Input over-voltage did not pull line b.");
   AST_OC_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
      faults_page0.overcurrent && propagate_reg[0][BIT_OVERCURRENT] |=> shared_fault_line_a_oe)
      else $error("Over-current did not pull line a.");
   AST_UV_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
      faults_page1.out_uv && propagate_reg[1][BIT_OUT_UV] |=> shared_fault_line_b_oe)
      else $error("Under-voltage did not pull line b.");
   AST_OV_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
      faults_page0.out_ov && propagate_reg[0][BIT_OUT_OV] |=> shared_fault_line_a_oe)
      else $error("Over-voltage did not pull line a.");
   AST_PAGE_SPLIT: assert property (@(posedge clk_sys) disable iff (rst)
      !page_pull(faults_page1, propagate_reg[1]) |=> !shared_fault_line_b_oe)
      else $error("Line b pulled without a page 1 cause.");
   AST_INHIBIT: assert property (@(posedge clk_sys) disable iff (rst)
      pulled_low[0] && response_reg[0] == RESP_INHIBIT |=> output_inhibit[0])
      else $error("Inhibit response did not three-state page 0.");
   AST_IGNORE: assert property (@(posedge clk_sys) disable iff (rst)
      response_reg[1] == RESP_IGNORE |=> !output_inhibit[1])
      else $error("Ignore response stopped page 1.");
   AST_STATUS_SET: assert property (@(posedge clk_sys) disable iff (rst)
      pulled_low[0] |=> status_pin_reg[0] && status_summary_reg[0])
      else $error("Pull low did not set status.");
   AST_ALERT: assert property (@(posedge clk_sys) disable iff (rst)
      pulled_low[1] && !mask_reg[1] && !mask_next[1] |=> !alert_n)
      else $error("Unmasked pull low did not raise alert.");
   AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      clear_faults && pulled_low == 2'h0 |=> alert_n && status_pin_reg == 2'h0)
      else $error("Clear faults left status set.");
   AST_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
      (propagate_reg[0] & ~PROPAGATE_WR_MASK) == 8'h00)
      else $error("Reserved propagation bits set.");

endmodule // fault_pin_share_response

// ### rtl/fault_share_pkg.sv
// Package of constants and carrier types for the shared fault line block.
package fault_share_pkg;
   // Number of pages, one shared fault line each.
   localparam int unsigned PAGE_COUNT = 2;

   // Command codes on the register port.
   localparam logic [7:0] CMD_FAULT_RESPONSE = 8'hD5;
   localparam logic [7:0] CMD_PROPAGATE_LOW  = 8'hD2;
   localparam logic [7:0] CMD_STATUS_WORD_HI = 8'h79;
   localparam logic [7:0] CMD_STATUS_MFR     = 8'h80;
   localparam logic [7:0] CMD_ALERT_MASK     = 8'h1B;

   // Response values and reset values.
   localparam logic [7:0] RESP_INHIBIT     = 8'hC0;
   localparam logic [7:0] RESP_IGNORE      = 8'h00;
   localparam logic [7:0] RESP_RESET       = 8'hC0;
   localparam logic [7:0] PROPAGATE_RESET  = 8'h00;
   localparam logic [7:0] ALERT_MASK_RESET = 8'h00;

   // Field positions in the propagation byte.
   localparam int unsigned BIT_OVERTEMP      = 7;
   localparam int unsigned BIT_INPUT_OV      = 4;
   localparam int unsigned BIT_OVERCURRENT   = 2;
   localparam int unsigned BIT_OUT_UV        = 1;
   localparam int unsigned BIT_OUT_OV        = 0;
   localparam logic [7:0]  PROPAGATE_WR_MASK = 8'h97;

   // Status bit positions.
   localparam int unsigned BIT_STATUS_MFR_SUMMARY = 4;
   localparam int unsigned BIT_MFR_PIN_PULLED     = 0;

   // Internal fault levels of one page.
   typedef struct packed {
      logic overtemp;
      logic input_ov;
      logic overcurrent;
      logic out_uv;
      logic out_ov;
   } page_faults_s;

   // One byte register access from the command decoder.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       page;
      logic [7:0] code;
      logic [7:0] data;
      logic [1:0] byte_count;
   } reg_access_s;
endpackage : fault_share_pkg

// ### verification/fault_line_partner.sv
// Other controllers sharing the two open-drain fault lines, each line with a pull-up.
`timescale 1ns/1ps
module fault_line_partner (
   input  wire logic pull_a,
   input  wire logic pull_b,
   input  wire logic dut_a_out,
   input  wire logic dut_a_oe,
   input  wire logic dut_b_out,
   input  wire logic dut_b_oe,
   output logic      line_a,
   output logic      line_b
);
   // Wired-AND of all parties; the pull-up sets the level only when nobody pulls low.
   assign line_a = (dut_a_oe ? dut_a_out : 1'b1) & ~pull_a;
   assign line_b = (dut_b_oe ? dut_b_out : 1'b1) & ~pull_b;
endmodule // fault_line_partner

// ### verification/tb_top.sv
// Self-checking bench for the shared fault line block.
`timescale 1ns/1ps
module tb_top;
   import fault_share_pkg::*;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1;
   reg_access_s  acc = '0;
   logic         clear_faults = 1'b0;
   page_faults_s flt0 = '0;
   page_faults_s flt1 = '0;
   logic         pull_a = 1'b0;
   logic         pull_b = 1'b0;
   logic         line_a, line_b, a_out, a_oe, b_out, b_oe, read_valid, bc_err, alert_n;
   logic [1:0]   inhibit;
   logic [7:0]   read_data;
   logic [7:0]   exp_q[$];
   logic [31:0]  seed = 32'h0000_7d87;
   int           fail_count = 0;
   int           check_count = 0;
   int           bitpos[5] = '{0, 1, 2, 4, 7};

   always #4 clk_sys = ~clk_sys;

   fault_pin_share_response fault_pin_share_response_inst (.clk_sys(clk_sys), .rst(rst),
      .reg_access(acc), .clear_faults(clear_faults), .faults_page0(flt0), .faults_page1(flt1),
      .shared_fault_line_a_in(line_a), .shared_fault_line_b_in(line_b),
      .shared_fault_line_a_out(a_out), .shared_fault_line_a_oe(a_oe),
      .shared_fault_line_b_out(b_out), .shared_fault_line_b_oe(b_oe), .output_inhibit(inhibit),
      .read_data(read_data), .read_valid(read_valid), .byte_count_error(bc_err),
      .alert_n(alert_n));
   fault_line_partner fault_line_partner_inst (.pull_a(pull_a), .pull_b(pull_b),
      .dut_a_out(a_out), .dut_a_oe(a_oe), .dut_b_out(b_out), .dut_b_oe(b_oe),
      .line_a(line_a), .line_b(line_b));

   ////////////////////////////////////////////////////////////////////////////////
   // Small xorshift generator, so the run repeats exactly from one seed.
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // One register access held for exactly one taking edge.
   task automatic access(input logic w, input logic r, input logic pg, input logic [7:0] cd,
                         input logic [7:0] dt, input logic [1:0] bc);
      @(posedge clk_sys);
      acc <= '{w, r, pg, cd, dt, bc};
      @(posedge clk_sys);
      acc <= '0;
   endtask

   task automatic wr(input logic pg, input logic [7:0] cd, input logic [7:0] dt);
      access(1'b1, 1'b0, pg, cd, dt, 2'h1);
   endtask

   // The expected byte is queued first; the monitor compares it when read_valid shows.
   task automatic rd(input logic pg, input logic [7:0] cd, input logic [7:0] exp);
      exp_q.push_back(exp);
      access(1'b0, 1'b1, pg, cd, 8'h00, 2'h0);
   endtask

   // Waits whole cycles, then lets registered outputs settle past the edge.
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic pulse_clear();
      @(posedge clk_sys);
      clear_faults <= 1'b1;
      @(posedge clk_sys);
      clear_faults <= 1'b0;
      settle(2);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Read monitor: the pre-edge value of read_valid is the registered answer.
   always @(posedge clk_sys) begin
      if (read_valid === 1'b1) begin
         chk(read_data, exp_q.pop_front());
      end
   end

   // Watchdog sized well above the few hundred cycles the sequence needs.
   initial begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(1'b0, CMD_FAULT_RESPONSE, 8'hC0);
      rd(1'b1, CMD_FAULT_RESPONSE, 8'hC0);
      for (int p = 0; p < 2; p++) begin
         seed = xorshift(seed);
         wr(p[0], CMD_PROPAGATE_LOW, seed[7:0] | 8'h68);
         rd(p[0], CMD_PROPAGATE_LOW, (seed[7:0] | 8'h68) & 8'h97);
      end
      // Each share bit alone, then every other bit, against its own fault.
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 5; k++) begin
            wr(p[0], CMD_PROPAGATE_LOW, 8'h01 << bitpos[k]);
            @(posedge clk_sys);
            if (p == 0) flt0 <= page_faults_s'(5'h01 << k);
            else flt1 <= page_faults_s'(5'h01 << k);
            settle(3);
            chk({7'h00, p ? b_oe : a_oe}, 8'h01);
            chk({7'h00, p ? a_oe : b_oe}, 8'h00);
            chk({6'h00, p ? line_b : line_a, p ? b_out : a_out}, 8'h00);
            wr(p[0], CMD_PROPAGATE_LOW, 8'hFF & ~(8'h01 << bitpos[k]));
            settle(3);
            chk({7'h00, p ? b_oe : a_oe}, 8'h00);
            @(posedge clk_sys);
            flt0 <= '0;
            flt1 <= '0;
         end
      end
      // Releasing our own pull must not look like an outside pull.
      settle(3);
      chk({7'h00, alert_n}, 8'h01);
      wr(1'b0, CMD_PROPAGATE_LOW, 8'h00);
      wr(1'b1, CMD_PROPAGATE_LOW, 8'h00);
      wr(1'b1, CMD_FAULT_RESPONSE, 8'h00);
      rd(1'b1, CMD_FAULT_RESPONSE, 8'h00);
      // Outside pull: page 0 keeps inhibit response, page 1 ignores.
      for (int p = 0; p < 2; p++) begin
         pulse_clear();
         chk({7'h00, alert_n}, 8'h01);
         @(posedge clk_sys);
         if (p == 0) pull_a <= 1'b1;
         else pull_b <= 1'b1;
         settle(5);
         chk({6'h00, inhibit}, p ? 8'h00 : 8'h01);
         chk({7'h00, alert_n}, 8'h00);
         rd(p[0], CMD_STATUS_WORD_HI, 8'h10);
         rd(p[0], CMD_STATUS_MFR, 8'h01);
         pulse_clear();
         chk({7'h00, alert_n}, 8'h00);
         @(posedge clk_sys);
         pull_a <= 1'b0;
         pull_b <= 1'b0;
         settle(5);
         chk({6'h00, inhibit}, 8'h00);
         pulse_clear();
         chk({7'h00, alert_n}, 8'h01);
      end
      // Masked source: status still records the pull, alert stays quiet.
      wr(1'b0, CMD_ALERT_MASK, 8'h01);
      wr(1'b1, CMD_ALERT_MASK, 8'h01);
      rd(1'b0, CMD_ALERT_MASK, 8'h01);
      @(posedge clk_sys);
      pull_a <= 1'b1;
      settle(5);
      chk({7'h00, alert_n}, 8'h01);
      rd(1'b0, CMD_STATUS_MFR, 8'h01);
      @(posedge clk_sys);
      pull_a <= 1'b0;
      // A response write with two data bytes is refused and leaves the value.
      access(1'b1, 1'b0, 1'b0, CMD_FAULT_RESPONSE, 8'h00, 2'h2);
      #1;
      chk({7'h00, bc_err}, 8'h01);
      rd(1'b0, CMD_FAULT_RESPONSE, 8'hC0);
      settle(4);
      complete_run();
   end
endmodule // tb_top
